// file: ewr_host.sv
// Behaviour
// - Automatic gain off stops adjustment; host then writes gain at 0x23.
// - Host writes gain only with automatic gain off, suppress bit set.
// - Read takes command then response; pipelined reads cost one each.
// - Read command: write clear, suppress as software sets, address, filler byte.
// - Host waits 300 us, 54 us reduced power, or 5 us suppressed.
// - Next transaction sends new command while response shifts back.
// - Host may end the wait when the interrupt output asserts.
// - Follow-up reads of related values set the suppress bit.
// - Write: suppress and write set, address, data; stored at release.
// - After a write wait 5 us; next response is discarded.
`timescale 1ns/1ps
module ewr_host
    import ewr_pkg::*;
#(
    parameter int P_HALF_CYC  = SCK_HALF_CYC,
    parameter int P_NORM_CYC  = NORM_CYC,
    parameter int P_LP_CYC    = LP_CYC,
    parameter int P_SHORT_CYC = SHORT_CYC
)(
    input  wire logic              I_CLK,     // 250 MHz clock
    input  wire logic              I_SYS_RST, // Sync reset, high
    input  wire logic [7:0]        I_ADDR,    // Software address
    input  wire logic [WORD_W-1:0] I_WDATA,   // Software write data
    input  wire logic              I_WR,      // Write strobe
    input  wire logic              I_RD,      // Read strobe
    output logic      [WORD_W-1:0] O_RDATA,   // Read data, next cycle
    output logic                   O_SCLK,    // Serial clock
    output logic                   O_CS_N,    // chip_select_n
    output logic                   O_MOSI,    // Serial data out
    input  wire logic              I_MISO,    // Serial data in
    input  wire logic              I_IRQ_N    // Device interrupt, low
);

    localparam int HALF = P_HALF_CYC;

    generate
        if (P_HALF_CYC < 4 || P_HALF_CYC > 255)
            $error("P_HALF_CYC out of range");
        if (P_NORM_CYC >= 2**WAIT_W || P_LP_CYC >= 2**WAIT_W)
            $error("Wait count too wide");
        if (P_SHORT_CYC < 1 || P_SHORT_CYC > P_LP_CYC)
            $error("Short wait out of range");
    endgenerate

    ewr_st_t            s;
    ewr_st_t            n;
    ewr_cmd_t           c;
    logic [WAIT_W-1:0]  wnext;

    function automatic logic wait_over(input logic [WAIT_W-1:0] cnt,
                                       input logic [WAIT_W-1:0] lim);
        wait_over = (cnt >= lim);
    endfunction

    always_comb
    begin
        n         = s;
        c         = ewr_cmd_t'(I_WDATA);
        wnext     = s.wait_cnt + 1'b1;
        n.miso_s1 = I_MISO;
        n.miso_s2 = s.miso_s1;
        n.irq_s1  = I_IRQ_N;
        n.irq_s2  = s.irq_s1;
        n.rdata   = '0;
        if (I_RD)
        begin
            unique case (I_ADDR)
                SW_CTRL:   n.rdata[CTRL_IRQ_BIT] = s.use_irq;
                SW_STAT:
                begin
                    n.rdata[STAT_BUSY_BIT] = (s.state != S_IDLE);
                    n.rdata[STAT_RVAL_BIT] = s.resp_valid;
                    n.rdata[STAT_REF_BIT]  = s.refused;
                    n.refused              = 1'b0;
                end
                SW_RESP:
                begin
                    n.rdata      = s.resp;
                    n.resp_valid = 1'b0;
                end
                SW_SHADOW: n.rdata[7:0] = s.shadow;
                default:   n.rdata = '0;
            endcase
        end
        if (I_WR && I_ADDR == SW_CTRL)
            n.use_irq = I_WDATA[CTRL_IRQ_BIT];
        unique case (s.state)
            S_IDLE:
            begin
                if (I_WR && I_ADDR == SW_CMD)
                begin
                    if (c.wr)
                        c.sup = 1'b1;
                    if (c.wr && c.addr == DEV_CFG_ADDR)
                        c.data = c.data & ~CFG_RSVD_MASK;
                    if (c.wr && c.addr == DEV_GAIN_ADDR && !s.shadow[CFG_NOAGC_BIT])
                        n.refused = 1'b1;
                    else
                    begin
                        n.cmd     = c;
                        n.tx      = c;
                        n.mosi    = c.sup;
                        n.cs_n    = 1'b0;
                        n.sclk    = 1'b0;
                        n.div     = '0;
                        n.bit_cnt = '0;
                        n.rx      = '0;
                        n.state   = S_SHIFT;
                    end
                end
            end
            S_SHIFT:
            begin
                if (I_WR && I_ADDR == SW_CMD)
                    n.refused = 1'b1;
                n.div = s.div + 1'b1;
                if (s.div == 8'(HALF - 1))
                begin
                    n.div  = '0;
                    n.sclk = ~s.sclk;
                    if (!s.sclk)
                        n.rx = {s.rx[WORD_W-2:0], s.miso_s2};
                    else if (s.bit_cnt == 4'hF)
                    begin
                        n.cs_n     = 1'b1;
                        n.mosi     = 1'b0;
                        n.state    = S_WAIT;
                        n.wait_cnt = '0;
                        // response after a write is dropped
                        if (s.prev_rd)
                        begin
                            n.resp       = s.rx;
                            n.resp_valid = 1'b1;
                        end
                        n.prev_rd = ~s.cmd.wr;
                        if (s.cmd.wr && s.cmd.addr == DEV_CFG_ADDR)
                            n.shadow = s.cmd.data;
                        n.trig = ~s.cmd.sup & ~s.shadow[CFG_SMOD_BIT];
                        if (s.cmd.sup || s.shadow[CFG_SMOD_BIT])
                            n.wait_tgt = WAIT_W'(P_SHORT_CYC);
                        else if (s.shadow[CFG_LPWR_BIT])
                            n.wait_tgt = WAIT_W'(P_LP_CYC);
                        else
                            n.wait_tgt = WAIT_W'(P_NORM_CYC);
                    end
                    else
                    begin
                        n.bit_cnt = s.bit_cnt + 1'b1;
                        n.tx      = {s.tx[WORD_W-2:0], 1'b0};
                        n.mosi    = s.tx[WORD_W-2];
                    end
                end
            end
            S_WAIT:
            begin
                if (I_WR && I_ADDR == SW_CMD)
                    n.refused = 1'b1;
                n.wait_cnt = wnext;
                // interrupt ends wait after short floor
                if (wait_over(wnext, s.wait_tgt) ||
                    (s.use_irq && s.trig && !s.irq_s2 &&
                     wait_over(wnext, WAIT_W'(P_SHORT_CYC))))
                    n.state = S_IDLE;
            end
            default: n.state = S_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            s        <= '0;
            s.cs_n   <= 1'b1;
            s.irq_s1 <= 1'b1;
            s.irq_s2 <= 1'b1;
            s.shadow <= CFG_RESET;
        end
        else
            s <= n;
    end

    assign O_RDATA = s.rdata;
    assign O_SCLK  = s.sclk;
    assign O_CS_N  = s.cs_n;
    assign O_MOSI  = s.mosi;

    logic [WAIT_W-1:0] hi_cnt;

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            hi_cnt <= {WAIT_W{1'b1}};
        else if (!s.cs_n)
            hi_cnt <= '0;
        else if (hi_cnt != {WAIT_W{1'b1}})
            hi_cnt <= hi_cnt + 1'b1;
    end

    logic [4:0] rise_cnt;

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            rise_cnt <= '0;
        else if (s.cs_n)
            rise_cnt <= '0;
        else if (n.sclk && !s.sclk)
            rise_cnt <= rise_cnt + 1'b1;
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    sequence seq_frame_start;
        $fell(s.cs_n);
    endsequence

    sequence seq_frame_end;
        $rose(s.cs_n);
    endsequence

    sequence seq_first_rise;
        !s.sclk [*2] ##[1:300] $rose(s.sclk);
    endsequence

    a_write_flags: assert property (
        seq_frame_start and s.cmd.wr |-> s.cmd.sup && s.tx[WORD_W-1] == 1'b1)
        else $error("Write sent without suppress");
    a_cfg_reserved: assert property (
        seq_frame_start and s.cmd.wr && s.cmd.addr == DEV_CFG_ADDR
        |-> (s.cmd.data & CFG_RSVD_MASK) == 8'h00)
        else $error("Reserved configuration bits set");
    a_gain_guard: assert property (
        seq_frame_start and s.cmd.wr && s.cmd.addr == DEV_GAIN_ADDR
        |-> s.shadow[CFG_NOAGC_BIT])
        else $error("Gain written with automatic gain on");
    a_wait_floor: assert property (
        seq_frame_start |-> $past(hi_cnt) >= WAIT_W'(P_SHORT_CYC))
        else $error("Chip select low before short wait");
    a_wait_full: assert property (
        seq_frame_start and !$past(s.use_irq) |-> $past(hi_cnt) >= $past(s.wait_tgt))
        else $error("Chip select low before full wait");
    a_sclk_lead: assert property (
        seq_frame_start |-> seq_first_rise)
        else $error("Clock started without lead time");
    a_sclk_idle: assert property (
        s.cs_n |-> !s.sclk)
        else $error("Serial clock toggling outside frame");
    a_resp_pair: assert property (
        $rose(s.resp_valid) |-> $past(s.prev_rd) && $rose(s.cs_n))
        else $error("Response marked valid without read");
    a_busy_refuse: assert property (
        I_WR && I_ADDR == SW_CMD && s.state != S_IDLE |=> s.refused)
        else $error("Command during transaction not refused");
    a_frame_bits: assert property (
        seq_frame_end |-> rise_cnt == 5'd16)
        else $error("Frame without sixteen clock rises");
    a_mosi_hold: assert property (
        s.sclk |-> $stable(s.mosi))
        else $error("Command bit changed while clock high");
    a_gain_refuse: assert property (
        I_WR && I_ADDR == SW_CMD && s.state == S_IDLE && I_WDATA[14] &&
        I_WDATA[13:8] == DEV_GAIN_ADDR && !s.shadow[CFG_NOAGC_BIT]
        |=> s.refused && s.cs_n)
        else $error("Gain write with automatic gain on not refused");
    a_write_drop: assert property (
        seq_frame_end and !$past(s.prev_rd) |-> $stable(s.resp))
        else $error("Response after write was stored");
    a_read_flags: assert property (
        seq_frame_start and !s.cmd.wr |-> s.tx[WORD_W-2] == 1'b0)
        else $error("Read sent with write bit set");
    a_irq_hold: assert property (
        s.state == S_WAIT && s.irq_s2 && n.state == S_IDLE
        |-> wnext >= s.wait_tgt)
        else $error("Wait ended without interrupt or full time");

endmodule

// file: ewr_pkg.sv
package ewr_pkg;

    localparam int          WORD_W        = 16;
    localparam int          WAIT_W        = 20;
    // Host-side software register map
    localparam logic [7:0]  SW_CTRL       = 8'h00;
    localparam logic [7:0]  SW_CMD        = 8'h01;
    localparam logic [7:0]  SW_STAT       = 8'h02;
    localparam logic [7:0]  SW_RESP       = 8'h03;
    localparam logic [7:0]  SW_SHADOW     = 8'h04;
    localparam int          CTRL_IRQ_BIT  = 0;
    localparam int          STAT_BUSY_BIT = 0;
    localparam int          STAT_RVAL_BIT = 1;
    localparam int          STAT_REF_BIT  = 2;
    // Device register map
    localparam logic [5:0]  DEV_POS_ADDR  = 6'h00;
    localparam logic [5:0]  DEV_CFG_ADDR  = 6'h21;
    localparam logic [5:0]  DEV_STAT_ADDR = 6'h22;
    localparam logic [5:0]  DEV_GAIN_ADDR = 6'h23;
    localparam int          CFG_SPOL_BIT  = 6;
    localparam int          CFG_SMOD_BIT  = 5;
    localparam int          CFG_IMOD_BIT  = 3;
    localparam int          CFG_NOAGC_BIT = 2;
    localparam int          CFG_LPWR_BIT  = 0;
    localparam logic [7:0]  CFG_RSVD_MASK = 8'h92;
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    // Timing
    localparam int          CLK_MHZ       = 250;
    localparam int          T_NORM_US     = 300;
    localparam int          T_LP_US       = 54;
    localparam int          T_SHORT_US    = 5;
    localparam int          NORM_CYC      = T_NORM_US * CLK_MHZ;
    localparam int          LP_CYC        = T_LP_US * CLK_MHZ;
    localparam int          SHORT_CYC     = T_SHORT_US * CLK_MHZ;
    localparam int          SCK_HALF_CYC  = 8;

    typedef struct packed {
        logic       sup;
        logic       wr;
        logic [5:0] addr;
        logic [7:0] data;
    } ewr_cmd_t;

    typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_WAIT} ewr_state_t;

    typedef struct packed {
        ewr_state_t         state;
        logic               miso_s1;
        logic               miso_s2;
        logic               irq_s1;
        logic               irq_s2;
        logic               sclk;
        logic               cs_n;
        logic               mosi;
        logic [7:0]         div;
        logic [3:0]         bit_cnt;
        ewr_cmd_t           cmd;
        logic [WORD_W-1:0]  tx;
        logic [WORD_W-1:0]  rx;
        logic [WAIT_W-1:0]  wait_cnt;
        logic [WAIT_W-1:0]  wait_tgt;
        logic               trig;
        logic               prev_rd;
        logic [WORD_W-1:0]  resp;
        logic               resp_valid;
        logic               refused;
        logic               use_irq;
        logic [7:0]         shadow;
        logic [WORD_W-1:0]  rdata;
    } ewr_st_t;

endpackage

// file: ewr_dev.sv
`timescale 1ns/1ps
module ewr_dev
    import ewr_pkg::*;
#(
    parameter int P_CONV = 60
)(
    input  wire logic        i_clk,   // Time base
    input  wire logic        i_sclk,  // Serial clock
    input  wire logic        i_cs_n,  // chip_select_n
    input  wire logic        i_mosi,  // Command in
    input  wire logic [29:0] i_amp,   // Sensor samples a, b, c
    input  wire logic        i_sample, // Sample pin
    output logic             o_miso,  // Response out
    output logic             o_irq_n  // Interrupt, low
);
    logic [7:0]  cfg  = 8'h00;
    logic [7:0]  gain = 8'h00;
    logic [2:1]  lvl  = 2'b00;
    logic [15:0] rx   = 16'h8000;
    logic [15:0] tx   = 16'h0000;
    logic [6:0]  pend = 7'h00;
    logic        last = 1'b0;
    logic        done = 1'b0;
    int          conv = 0;
    logic [9:0]  m0, m1, m2;
    logic        lo, hi;
    assign m0 = i_amp[29] ? 10'h000 - i_amp[29:20] : i_amp[29:20];
    assign m1 = i_amp[19] ? 10'h000 - i_amp[19:10] : i_amp[19:10];
    assign m2 = i_amp[9] ? 10'h000 - i_amp[9:0] : i_amp[9:0];
    assign lo = m0 < 10'h100 && m1 < 10'h100 && m2 < 10'h100;
    assign hi = m0 > 10'h1FA || m1 > 10'h1FA || m2 > 10'h1FA;
    assign o_irq_n = ~(cfg[CFG_IMOD_BIT] | done);
    // Released line shows the inverse of its last bit
    assign o_miso = i_cs_n ? ~last : tx[15];
    always @(negedge i_cs_n)
    begin
        done = 1'b0;
        case (pend)
            {1'b1, DEV_CFG_ADDR}:  tx = {8'h00, cfg};
            {1'b1, DEV_STAT_ADDR}: tx = {13'h0000, lvl, conv > 0};
            {1'b1, DEV_GAIN_ADDR}: tx = {8'h00, gain};
            default:               tx = {~last, 15'h5A3C};
        endcase
    end
    always @(posedge i_sclk)
        if (!i_cs_n)
            rx = {rx[14:0], i_mosi};
    always @(negedge i_sclk)
        if (!i_cs_n)
            tx = {tx[14:0], ~tx[15]};
    always @(posedge i_cs_n)
    begin
        last = tx[15];
        pend = {~rx[14], rx[13:8]};
        if (rx[14] && rx[13:8] == DEV_CFG_ADDR)
            cfg = rx[7:0];
        if (rx[14] && rx[13:8] == DEV_GAIN_ADDR)
            gain = {3'b000, rx[4:0]};
        if (!rx[15] && !cfg[CFG_SMOD_BIT])
            conv = cfg[CFG_LPWR_BIT] ? P_CONV / 4 : P_CONV;
    end
    always @(negedge i_sample)
        if (!cfg[CFG_SPOL_BIT])
            conv = cfg[CFG_LPWR_BIT] ? P_CONV / 4 : P_CONV;
    always @(posedge i_sample)
        if (cfg[CFG_SPOL_BIT])
            conv = cfg[CFG_LPWR_BIT] ? P_CONV / 4 : P_CONV;
    always @(posedge i_clk)
        if (conv > 0)
        begin
            conv = conv - 1;
            if (conv == 0)
            begin
                lvl  = {lo, hi};
                done = 1'b1;
                if (!cfg[CFG_NOAGC_BIT] && hi && gain > 0)
                    gain = gain - 1;
                else if (!cfg[CFG_NOAGC_BIT] && lo && gain < 17)
                    gain = gain + 1;
            end
        end
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
    import ewr_pkg::*;
    typedef struct packed {logic [7:0] a; logic [15:0] e; logic [15:0] m;} ewr_exp_t;
    localparam logic [29:0] AMP [3] = '{{10'h0FF, 10'h301, 10'h000},
                                        {10'h1FA, 10'h100, 10'h000},
                                        {10'h000, 10'h205, 10'h000}};
    localparam logic [7:0]  LVL [3] = '{8'h04, 8'h00, 8'h02};
    logic              clk     = 1'b0;
    logic              sys_rst = 1'b1;
    logic [7:0]        addr    = 8'h00;
    logic [WORD_W-1:0] wdata   = 16'h0000;
    logic              wr_s    = 1'b0;
    logic              rd_s    = 1'b0;
    logic              rd_q    = 1'b0;
    logic              smp     = 1'b1;
    logic [29:0]       amp     = 30'h0000_0000;
    logic [15:0]       seed    = 16'h004D;
    logic [WORD_W-1:0] rdata;
    logic              sclk, cs_n, mosi, miso, irq_n;
    ewr_exp_t          expq [$];
    ewr_exp_t          x;
    logic [15:0]       v;
    int                n;
    int                n_fail = 0;
    int                samples_checked = 0;
    ewr_host #(.P_HALF_CYC(4), .P_NORM_CYC(200), .P_LP_CYC(100), .P_SHORT_CYC(20)) u_ewr_host (
        .I_CLK(clk), .I_SYS_RST(sys_rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
        .I_RD(rd_s), .O_RDATA(rdata), .O_SCLK(sclk), .O_CS_N(cs_n), .O_MOSI(mosi),
        .I_MISO(miso), .I_IRQ_N(irq_n));
    ewr_dev #(.P_CONV(60)) u_ewr_dev (.i_clk(clk), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_mosi(mosi), .i_amp(amp), .i_sample(smp), .o_miso(miso), .o_irq_n(irq_n));
    initial
        forever #2 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic compare(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic sw_wr(input logic [7:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask
    task automatic sw_rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        addr <= a;
        rd_s <= 1'b1;
        expq.push_back('{a, e, m});
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        v = rdata;
        @(posedge clk);
    endtask
    task automatic wait_idle();
        n = 0;
        v = 16'h0001;
        while (v[STAT_BUSY_BIT] !== 1'b0 && n < 4000)
        begin
            sw_rd(SW_STAT, 16'h0000, 16'h0000);
            n += 2;
        end
        if (n >= 4000)
            n_fail++;
    endtask
    task automatic run_cmd(input logic s, input logic w, input logic [5:0] a, input logic [7:0] d);
        seed = lfsr(seed);
        sw_wr(SW_CMD, {s, w, a, w ? d : seed[7:0]});
        wait_idle();
    endtask
    always @(posedge clk)
    begin
        rd_q <= rd_s;
        if (rd_q && expq.size() > 0)
        begin
            x = expq.pop_front();
            if (x.m !== 16'h0000)
                compare($sformatf("register %h", x.a), x.e, rdata & x.m);
        end
    end
    initial
    begin
        repeat (50000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        sw_rd(SW_STAT, 16'h0000, 16'hFFFF);
        sw_rd(SW_SHADOW, {8'h00, CFG_RESET}, 16'hFFFF);
        sw_rd(8'h07, 16'h0000, 16'hFFFF);
        sw_wr(SW_CMD, {2'b11, DEV_GAIN_ADDR, 8'h05});
        sw_rd(SW_STAT, 16'h0004, 16'h0007);
        run_cmd(1'b0, 1'b1, DEV_CFG_ADDR, 8'h96);
        compare("write wait", 16'h0001, {15'h0000, n < 200});
        sw_rd(SW_SHADOW, 16'h0004, 16'hFFFF);
        addr  <= SW_CMD;
        wdata <= {2'b11, DEV_GAIN_ADDR, 8'hF1};
        wr_s  <= 1'b1;
        @(posedge clk);
        wdata <= {2'b11, DEV_GAIN_ADDR, 8'h03};
        @(posedge clk);
        wr_s  <= 1'b0;
        sw_rd(SW_STAT, 16'h0005, 16'h0005);
        wait_idle();
        run_cmd(1'b1, 1'b0, DEV_CFG_ADDR, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            amp <= AMP[k];
            run_cmd(1'b0, 1'b0, DEV_STAT_ADDR, 8'h00);
            sw_rd(SW_RESP, k == 0 ? 16'h0004 : 16'h0011, 16'hFFFF);
            run_cmd(1'b1, 1'b0, DEV_GAIN_ADDR, 8'h00);
            sw_rd(SW_RESP, {8'h00, LVL[k]}, 16'hFFFF);
        end
        run_cmd(1'b1, 1'b1, DEV_CFG_ADDR, 8'h00);
        run_cmd(1'b0, 1'b0, DEV_STAT_ADDR, 8'h00);
        compare("full wait", 16'h0001, {15'h0000, n >= 300});
        run_cmd(1'b1, 1'b0, DEV_GAIN_ADDR, 8'h00);
        sw_rd(SW_RESP, 16'h0002, 16'hFFFF);
        run_cmd(1'b1, 1'b0, DEV_GAIN_ADDR, 8'h00);
        sw_rd(SW_RESP, 16'h0010, 16'hFFFF);
        sw_wr(SW_CTRL, 16'h0001);
        @(posedge clk);
        run_cmd(1'b0, 1'b0, DEV_STAT_ADDR, 8'h00);
        compare("irq wait", 16'h0001, {15'h0000, n < 260});
        run_cmd(1'b1, 1'b1, DEV_CFG_ADDR, 8'h20);
        amp <= AMP[0];
        smp <= 1'b0;
        repeat (80) @(posedge clk);
        run_cmd(1'b1, 1'b0, DEV_GAIN_ADDR, 8'h00);
        run_cmd(1'b1, 1'b0, DEV_GAIN_ADDR, 8'h00);
        sw_rd(SW_RESP, 16'h0010, 16'hFFFF);
        report_and_stop();
    end
endmodule
